// >>> rtl/abs_xfer_pkg.sv
// constants, types and state encodings for the absolute position handshake
// assumes a single 20 MHz clock and an APB master in the same clock domain
//
// Overview of operation
// R1: data bit zero replaces positioning-complete output
// R2: data bit one replaces zero-speed output
// R3: torque-limit output becomes the ready line
// R4: host keeps motor stopped during transfer
// R5: host keeps torque limiting off during transfer
// R6: transfer starts on drive-enable rising edge
// R7: host repeats transfer at power-up, controller reset
// R8: host repeats transfer after alarm, emergency stop
// R9: host checks checksum, flags sum error
// R10: host times mode, request and ready phases
// R11: host flags error if mode phase overruns
// R12: ready drops within one second of request
// R13: host retries, flags after four mismatches
// R14: each request returns two bits, ready-qualified
package abs_xfer_pkg;

   // clock and handshake timing
   localparam int CLOCK_PERIOD_NS  = 50;
   localparam int RESP_TIME_NS     = 100000;   // settle time before presenting a bit pair
   localparam int RESP_CYCLES      = (RESP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int READY_LIMIT_NS   = 1000000000; // host tolerance for the ready drop
   localparam int WAIT_W           = 12;
   localparam logic [WAIT_W-1:0] RESP_COUNT = WAIT_W'(RESP_CYCLES - 1);

   // frame layout: sixteen position pairs, then three checksum pairs
   localparam logic [4:0] POS_PAIRS = 5'h10;
   localparam logic [4:0] NUM_PAIRS = 5'h13;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET       = 8'h00;
   localparam logic [7:0] STATUS_OFFSET     = 8'h04;
   localparam logic [7:0] POSITION_OFFSET   = 8'h08;
   localparam logic [7:0] CHECKSUM_OFFSET   = 8'h0c;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h14;

   // field positions and reset values
   localparam int CTRL_ENABLE_BIT    = 0;
   localparam int STATUS_ACTIVE_BIT  = 3;
   localparam int STATUS_PAIR_LSB    = 4;
   localparam int IRQ_START_BIT      = 0;
   localparam int IRQ_DONE_BIT       = 1;
   localparam int IRQ_ABORT_BIT      = 2;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // handshake lines driven by the host
   typedef struct packed {
      logic driveEnable;
      logic transferMode;
      logic transferRequest;
   } host_lines_type;

   // shared status outputs toward the host
   typedef struct packed {
      logic positionDone;   // positioning complete, or data bit zero
      logic zeroSpeed;      // zero speed, or data bit one
      logic torqueLimit;    // torque limiting, or ready line
   } status_pins_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARMED,
      ST_WAIT_REQ,
      ST_LOAD,
      ST_PRESENT,
      ST_DONE
   } xfer_state_type;

endpackage : abs_xfer_pkg

// >>> rtl/line_sync.sv
// two-stage synchroniser for a group of independent level inputs
// assumes each bit is a slow level; no multi-bit coherence is promised
`timescale 1ns/1ps
module line_sync
#(
   parameter int WIDTH = 3
)
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             srst,
   // levels
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_q;   // metastable stage, read only by stage two

   // both stages clear on reset so edges after release are seen
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         stage1_q <= '0;
         syncOut  <= '0;
      end
      else
      begin
         stage1_q <= asyncIn;
         syncOut  <= stage1_q;
      end
   end

endmodule : line_sync

// >>> rtl/abs_position_transfer_handshake.sv
// driver-side absolute position handover over shared status pins
// assumes host lines arrive asynchronously and the APB master runs on clock
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module abs_position_transfer_handshake
   import abs_xfer_pkg::*;
(
   // clock and reset
   input  wire logic            clock,
   input  wire logic            srst,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // interrupt
   output logic                 irq,
   // host handshake lines, asynchronous
   input  wire host_lines_type  hostLines,
   // motion status and encoder, same clock
   input  wire status_pins_type motionStatus,
   input  wire logic [31:0]     absolutePosition,
   // shared status outputs toward the host
   output status_pins_type      statusPins
);

   // whole module state in one record
   typedef struct packed {
      xfer_state_type  state;
      logic [4:0]      pairIdx;      // pair being handed over
      logic [WAIT_W-1:0] waitCnt;    // settle counter before ready rises
      logic [31:0]     position;     // latched frame
      logic [5:0]      checksum;     // sum of the sixteen position pairs
      logic [1:0]      dataBits;     // pair on the data pins
      logic            readyFlag;    // ready line value during transfer
      status_pins_type pins;         // registered pin drive
      logic            enable;       // software permits transfers
      logic [2:0]      irqStatus;    // sticky events
      logic [2:0]      irqMask;      // interrupt gate
      logic [31:0]     rdData;       // captured read data
      logic            rdy;          // second access cycle
      logic            driveEnPrev;  // for edge detection
   } core_type;

   core_type        s_q;             // registered state
   core_type        s_d;             // next state
   host_lines_type  hostSync;        // synchronised host lines

   // host lines cross into the clock domain through two flops each
   line_sync #(.WIDTH(3)) hostSyncInst
   (
      .clock   (clock),
      .srst    (srst),
      .asyncIn (hostLines),
      .syncOut (hostSync)
   );

   // handshake outputs straight from state
   assign pready  = s_q.rdy;
   assign prdata  = s_q.rdData;
   assign irq     = |(s_q.irqStatus & s_q.irqMask);
   assign statusPins = s_q.pins;

   // decode of mapped offsets
   logic mapped;     // access hits a register
   always_comb
   begin
      case (paddr)
         CTRL_OFFSET, STATUS_OFFSET, POSITION_OFFSET,
         CHECKSUM_OFFSET, IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET: mapped = 1'b1;
         default:                                             mapped = 1'b0;
      endcase
   end
   assign pslverr = s_q.rdy & ~mapped;

   // next-state logic: transfer sequencer, apb slave and interrupts
   always_comb
   begin
      logic [2:0]  events;      // events raised this cycle
      logic [5:0]  sum;         // checksum accumulator
      logic [31:0] posShift;    // position aligned on the current pair
      logic [5:0]  sumShift;    // checksum aligned on the current pair
      logic [4:0]  sumIdx;      // checksum pair index
      logic        active;      // pins carry transfer data
      logic        accessEdge;  // apb access completes at this edge
      events     = 3'h0;
      sum        = 6'h00;
      posShift   = 32'h0;
      sumShift   = 6'h00;
      sumIdx     = 5'h00;
      active     = 1'b0;
      accessEdge = 1'b0;
      s_d        = s_q;
      s_d.driveEnPrev = hostSync.driveEnable;

      // checksum of the live encoder value, latched with the frame
      for (int i = 0; i < 16; i++)
      begin
         sum = sum + {4'h0, absolutePosition[2*i +: 2]};
      end

      // pair selection for the data pins
      posShift = s_q.position >> {s_q.pairIdx, 1'b0};
      sumIdx   = s_q.pairIdx - POS_PAIRS;
      sumShift = s_q.checksum >> {sumIdx[1:0], 1'b0};

      case (s_q.state)
         // waiting for a drive-enable rising edge
         ST_IDLE:
         begin
            s_d.readyFlag = 1'b0;
            // R6: start on edge
            if (hostSync.driveEnable && !s_q.driveEnPrev && s_q.enable)
            begin
               s_d.state = ST_ARMED;
            end
         end
         // edge seen; the frame is latched once the host selects transfer mode
         ST_ARMED:
         begin
            if (!hostSync.driveEnable)
            begin
               s_d.state = ST_IDLE;
            end
            else if (hostSync.transferMode)
            begin
               s_d.position  = absolutePosition;
               s_d.checksum  = sum;
               s_d.pairIdx   = 5'h00;
               s_d.readyFlag = 1'b1;
               s_d.state     = ST_WAIT_REQ;
               events[IRQ_START_BIT] = 1'b1;
            end
         end
         // ready high; wait for the next request
         ST_WAIT_REQ:
         begin
            if (hostSync.transferRequest)
            begin
               // R12: drop ready
               s_d.readyFlag = 1'b0;
               s_d.waitCnt   = RESP_COUNT;
               s_d.state     = ST_LOAD;
            end
         end
         // ready low; settle, then place the pair and raise ready
         ST_LOAD:
         begin
            if (s_q.waitCnt != '0)
            begin
               s_d.waitCnt = s_q.waitCnt - 1'b1;
            end
            else
            begin
               // R14: pair and ready on the same edge
               s_d.dataBits  = (s_q.pairIdx < POS_PAIRS) ? posShift[1:0] : sumShift[1:0];
               s_d.readyFlag = 1'b1;
               s_d.state     = ST_PRESENT;
            end
         end
         // pair valid; the host releases the request once read
         ST_PRESENT:
         begin
            if (!hostSync.transferRequest)
            begin
               s_d.pairIdx = s_q.pairIdx + 1'b1;
               s_d.state   = (s_q.pairIdx == NUM_PAIRS - 1'b1) ? ST_DONE : ST_WAIT_REQ;
               if (s_q.pairIdx == NUM_PAIRS - 1'b1)
               begin
                  events[IRQ_DONE_BIT] = 1'b1;
               end
            end
         end
         // all pairs sent; hold until the host leaves transfer mode
         ST_DONE:
         begin
            if (!hostSync.transferMode)
            begin
               s_d.state = ST_IDLE;
            end
         end
         default:
         begin
            s_d.state = ST_IDLE;
         end
      endcase

      // host leaving transfer mode or drive enable early aborts the frame
      if ((s_q.state == ST_WAIT_REQ || s_q.state == ST_LOAD || s_q.state == ST_PRESENT)
          && (!hostSync.transferMode || !hostSync.driveEnable))
      begin
         s_d.state     = ST_IDLE;
         s_d.readyFlag = 1'b0;
         events[IRQ_ABORT_BIT] = 1'b1;
      end

      // pins carry the frame only while transfer mode is held
      active = hostSync.transferMode && (s_q.state inside {ST_WAIT_REQ, ST_LOAD, ST_PRESENT, ST_DONE});
      // R1: bit zero pin
      s_d.pins.positionDone = active ? s_d.dataBits[0] : motionStatus.positionDone;
      // R2: bit one pin
      s_d.pins.zeroSpeed    = active ? s_d.dataBits[1] : motionStatus.zeroSpeed;
      // R3: ready on torque pin
      s_d.pins.torqueLimit  = active ? s_d.readyFlag : motionStatus.torqueLimit;

      // apb: first access cycle captures read data, second completes
      if (psel && penable && !s_q.rdy)
      begin
         s_d.rdy = 1'b1;
         case (paddr)
            CTRL_OFFSET:       s_d.rdData = {31'h0, s_q.enable};
            STATUS_OFFSET:     s_d.rdData = {23'h0, s_q.pairIdx, active, s_q.state};
            POSITION_OFFSET:   s_d.rdData = s_q.position;
            CHECKSUM_OFFSET:   s_d.rdData = {26'h0, s_q.checksum};
            IRQ_STATUS_OFFSET: s_d.rdData = {29'h0, s_q.irqStatus};
            IRQ_MASK_OFFSET:   s_d.rdData = {29'h0, s_q.irqMask};
            default:           s_d.rdData = 32'h0;
         endcase
      end
      else if (s_q.rdy)
      begin
         accessEdge = 1'b1;
         s_d.rdy    = 1'b0;
      end

      // writes take effect only at the completing edge
      if (accessEdge && pwrite)
      begin
         case (paddr)
            CTRL_OFFSET:       s_d.enable    = pwdata[CTRL_ENABLE_BIT];
            IRQ_STATUS_OFFSET: s_d.irqStatus = s_q.irqStatus & ~pwdata[2:0];
            IRQ_MASK_OFFSET:   s_d.irqMask   = pwdata[2:0];
            default:           s_d.irqMask   = s_d.irqMask;
         endcase
      end

      // a new event wins over a clear in the same cycle
      s_d.irqStatus = s_d.irqStatus | events;
   end

   // single state register; reset leaves pins at motion-status zero
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_q           <= '0;
         s_q.state     <= ST_IDLE;
         s_q.enable    <= CTRL_ENABLE_RESET;
         s_q.irqMask   <= IRQ_MASK_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

endmodule : abs_position_transfer_handshake

// >>> verif/abs_xfer_checker.sv
// port assertions for the position handover block
// assumes one clock domain; bound to the block below
`timescale 1ns/1ps
module abs_xfer_checker
   import abs_xfer_pkg::*;
(
   // clock and reset
   input logic            clock,
   input logic            srst,
   // apb answer side
   input logic            psel,
   input logic            penable,
   input logic            pready,
   input logic            pslverr,
   // handshake pins
   input host_lines_type  hostLines,
   input status_pins_type motionStatus,
   input status_pins_type statusPins
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   logic [2:0] idleCnt_q; // cycles with transfer mode low, saturating

   // sync and output stages must drain before pins pass motion status
   always_ff @(posedge clock)
      if (srst || hostLines.transferMode) idleCnt_q <= 3'h0;
      else if (idleCnt_q != 3'h7) idleCnt_q <= idleCnt_q + 3'h1;

   // a freshly placed pair stays put while the host reads it
   sequence pairHeld;
      $stable(statusPins) [*3];
   endsequence

   chk_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer not one wait state");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_idle_pass:
      assert property (idleCnt_q >= 3'h5 |-> statusPins == $past(motionStatus))
      else $error("pins not showing motion status");
   chk_ready_drop:
      assert property ($rose(hostLines.transferRequest) && hostLines.transferMode && statusPins.torqueLimit
                       |-> ##[1:8] !statusPins.torqueLimit)
      else $error("ready did not drop after request");
   chk_ready_wait:
      assert property ($fell(statusPins.torqueLimit) && hostLines.transferMode |=> !statusPins.torqueLimit [*8])
      else $error("ready came back too soon");
   chk_pair_held:
      assert property ($rose(statusPins.torqueLimit) && hostLines.transferRequest |=> pairHeld)
      else $error("pair changed while being read");
endmodule : abs_xfer_checker

bind abs_position_transfer_handshake abs_xfer_checker u_chk (.clock(clock), .srst(srst), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .hostLines(hostLines),
   .motionStatus(motionStatus), .statusPins(statusPins));

// >>> verif/abs_host_model.sv
// host controller model running the position handover
// assumes the block's registered pins and the same clock
`timescale 1ns/1ps
module abs_host_model
   import abs_xfer_pkg::*;
(
   // clock
   input  wire logic       clock,
   // pins
   input  status_pins_type statusPins,
   output host_lines_type  hostLines
);
   logic [31:0] pos;     // assembled position
   logic [5:0]  sum;     // received checksum
   int          linkErr; // handshake timeouts
   int          sumErr;  // checksum errors, raised after four bad frames in a row
   logic        sumBad;  // last full frame failed its checksum

   initial
   begin
      hostLines = '0;
      linkErr = 0;
      sumErr = 0;
      sumBad = 1'b0;
   end

   // wait for a ready level, bounded so a dead link cannot hang us
   task automatic waitReady(input logic lvl, input int limit);
      int n;
      n = 0;
      while (statusPins.torqueLimit !== lvl && n < limit)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= limit) linkErr++;
   endtask : waitReady

   // one handover; fewer than nineteen pairs leaves it aborted
   task automatic runFrame(input int pairs);
      logic [5:0] calc;
      calc = 6'h0;
      @(posedge clock) hostLines.driveEnable <= 1'b1;
      @(posedge clock) hostLines.transferMode <= 1'b1;
      waitReady(1'b1, 40);
      for (int i = 0; i < pairs; i++)
      begin
         @(posedge clock) hostLines.transferRequest <= 1'b1;
         waitReady(1'b0, 20);
         waitReady(1'b1, 2100);
         if (i < 16) pos[2*i +: 2] = {statusPins.zeroSpeed, statusPins.positionDone};
         else sum[2*(i-16) +: 2] = {statusPins.zeroSpeed, statusPins.positionDone};
         repeat (3) @(posedge clock);
         hostLines.transferRequest <= 1'b0;
         repeat (6) @(posedge clock);
      end
      for (int k = 0; k < 16; k++) calc += 6'(pos[2*k +: 2]);
      sumBad = (pairs == 19) && (calc != sum);
      @(posedge clock) hostLines.transferMode <= 1'b0;
      hostLines.driveEnable <= 1'b0;
   endtask : runFrame

   // retry on mismatch, flag after four in a row
   task automatic readPosition();
      int tries;
      tries = 0;
      do
      begin
         // let the driver settle back to idle before a retry
         if (tries > 0) repeat (10) @(posedge clock);
         runFrame(19);
         tries++;
      end
      while (sumBad && tries < 4);
      if (sumBad) sumErr++;
   endtask : readPosition

   // drive enable tied active, as across a driver restart
   task automatic holdEnable();
      @(posedge clock) hostLines.driveEnable <= 1'b1;
   endtask : holdEnable
endmodule : abs_host_model

// >>> verif/abs_position_transfer_handshake_test.sv
// self-checking bench for the position handover block
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module abs_position_transfer_handshake_test
   import abs_xfer_pkg::*;
   ;
   logic            clock = 1'b0;
   logic            srst = 1'b1;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            irq;
   host_lines_type  hostLines;
   status_pins_type statusPins;
   status_pins_type motionStatus = 3'h6;
   logic [31:0]     absolutePosition = 32'ha5c3_1e7b; // encoder value
   logic [31:0]     rd;
   logic            err;
   int              errorCnt = 0;
   int              comparisons = 0;
   int              cycles = 0;

   always #25 clock = ~clock;

   abs_position_transfer_handshake u_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .hostLines(hostLines), .motionStatus(motionStatus), .absolutePosition(absolutePosition),
      .statusPins(statusPins));
   abs_host_model u_host (.clock(clock), .statusPins(statusPins), .hostLines(hostLines));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; holds the request until pready is sampled
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clock) penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      // a slave that never answers counts against the run
      if (pready !== 1'b1) errorCnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [5:0] sumOf(input logic [31:0] p);
      sumOf = 6'h0;
      for (int k = 0; k < 16; k++) sumOf += 6'(p[2*k +: 2]);
   endfunction : sumOf

   task automatic checkRegs();
      apb(1'b0, CTRL_OFFSET, 32'h0);
      check(rd[CTRL_ENABLE_BIT], CTRL_ENABLE_RESET);
      apb(1'b0, IRQ_MASK_OFFSET, 32'h0);
      check(rd[2:0], IRQ_MASK_RESET);
      apb(1'b0, 8'h20, 32'h0);
      check({rd[30:0], err}, 32'h1);
      apb(1'b1, IRQ_MASK_OFFSET, 32'h2);
   endtask : checkRegs

   task automatic fullFrame();
      u_host.readPosition();
      check(u_host.pos, absolutePosition);
      check(u_host.sum, sumOf(absolutePosition));
      check(32'(u_host.linkErr + u_host.sumErr), 32'h0);
      check(irq, 1'b1);
      apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      check(rd[2:0], 3'h3);
      apb(1'b1, IRQ_STATUS_OFFSET, 32'h3);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      apb(1'b0, POSITION_OFFSET, 32'h0);
      check(rd, absolutePosition);
      apb(1'b0, CHECKSUM_OFFSET, 32'h0);
      check(rd[5:0], sumOf(absolutePosition));
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check(rd[STATUS_PAIR_LSB +: 5], NUM_PAIRS);
      check(rd[STATUS_ACTIVE_BIT], 1'b0);
   endtask : fullFrame

   task automatic abortFrame();
      @(posedge clock) motionStatus <= 3'h2;
      u_host.runFrame(3);
      repeat (6) @(posedge clock);
      check(statusPins, 3'h2);
      check(irq, 1'b0);
      apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      check(rd[2:0], 3'h5);
   endtask : abortFrame

   // driver restart with drive enable already high still starts a frame
   task automatic restartFrame();
      u_host.holdEnable();
      @(posedge clock) srst <= 1'b1;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      // host runs a one-pair transfer after the restart
      u_host.runFrame(1);
      repeat (6) @(posedge clock);
      check(32'(u_host.linkErr), 32'h0);
      check(irq, 1'b0);
      apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      check(rd[2:0], 3'h5);
   endtask : restartFrame

   // software disable keeps the pins on motion status
   task automatic disabledFrame();
      apb(1'b1, CTRL_OFFSET, 32'h0);
      apb(1'b1, IRQ_STATUS_OFFSET, 32'h7);
      u_host.runFrame(0);
      repeat (6) @(posedge clock);
      check(32'(u_host.linkErr), 32'h1);
      check(statusPins, 3'h2);
      apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      check(rd[2:0], 3'h0);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check(rd[2:0], 3'h0);
   endtask : disabledFrame

   task automatic results();
      $display("errors %0d, comparisons %0d", errorCnt, comparisons);
      if (errorCnt == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   // hang guard well above the whole sequence of scenarios
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         errorCnt++;
         results();
      end
   end

   initial
   begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      checkRegs();
      fullFrame();
      abortFrame();
      restartFrame();
      disabledFrame();
      results();
   end
endmodule : abs_position_transfer_handshake_test
